// ### rtl/ipr_pkg.sv
// constants shared by the paged register access front end
// assumes a 100 MHz system clock and byte wide register offsets
package ipr_pkg;
	// bus address
	localparam logic [4:0] ADDR_FIXED = 5'h0c;
	// direct register offsets
	localparam logic [7:0] OFS_INT_MASK = 8'hf0;
	localparam logic [7:0] OFS_INT_STATUS = 8'hf1;
	localparam logic [7:0] OFS_IDENT = 8'hfc;
	localparam logic [7:0] OFS_PAGE_SELECT = 8'hfd;
	localparam logic [7:0] OFS_PAGE_LOCK = 8'hfe;
	localparam logic [7:0] OFS_LOCAL_BASE = 8'hf0;
	// reset values and keys
	localparam logic [7:0] RST_INT_MASK = 8'h00;
	localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
	localparam logic [7:0] RST_PAGE_LOCK = 8'h00;
	localparam logic [7:0] PAGE_UNLOCK_KEY = 8'hc5;
	localparam logic [7:0] PAGE_MAX = 8'h04;
	// field positions
	localparam int BIT_AUTO_CLEAR = 4;
	localparam int BIT_SHORT = 1;
	localparam int BIT_OPEN = 0;
	// timing
	localparam int CLK_KHZ = 100000;
	localparam int AUTO_CLEAR_MS = 8;
	localparam int AUTO_CLEAR_CYC = AUTO_CLEAR_MS * CLK_KHZ;
	// bits per byte plus count at which the byte is complete
	localparam logic [3:0] BYTE_DONE = 4'h8;
	// clocks after reset until the pin sync chain holds real pin levels
	localparam logic [2:0] SYNC_SETTLE = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ACK_ADDR = 4'b0010,
		ST_REG = 4'b0011,
		ST_ACK_REG = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_ACK_W = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_ACK_R = 4'b1000
	} ipr_state_t;
endpackage

// ### rtl/ipr_top.sv
// i2c slave front end with paged register access, lock key and interrupt output
// assumes open-drain sda resolved outside, register pages served by logic on mclk
`timescale 1ns/100ps
`default_nettype none

module ipr_top #(
	parameter int AUTO_CLR_CYCLES = ipr_pkg::AUTO_CLEAR_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic addr_strap,
	// events from the detection engine
	input wire logic short_event,
	input wire logic open_event,
	// paged register side
	output logic [7:0] reg_page,
	output logic reg_wr,
	output logic [7:0] reg_wr_addr,
	output logic [7:0] reg_wdata,
	output logic [7:0] reg_rd_addr,
	input wire logic [7:0] reg_rdata,
	// interrupt pin
	output logic interrupt_out_n
);
	import ipr_pkg::*;

	// elaboration guard: the low time counter is only twenty bits wide
	if (AUTO_CLR_CYCLES < 1 || AUTO_CLR_CYCLES > 1048575) begin : g_bad_auto_clr
		$error("auto clear count out of range");
	end

	logic [2:0] sync1, sync2, sync3, filt, filt_d;
	logic scl_f, sda_f, strap_f, scl_rise, scl_fall, start_det, stop_det;
	ipr_state_t st;
	logic [3:0] cnt;
	logic [7:0] shreg, txreg, ptr, int_mask, lock, int_status;
	logic rw;
	logic seen_low, seen_high, seen_ne_scl, seen_ne_sda;
	logic [1:0] strap_bits;
	logic [6:0] own_addr;
	logic byte_in, wr_now, load_rd, page_wr, irq_cond, expired;
	logic [19:0] low_cnt;
	logic [7:0] rd_local;
	logic [2:0] settle;

	// three stage sync; filt only moves when stages two and three agree
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			sync3 <= 3'h7;
			filt <= 3'h7;
			filt_d <= 3'h7;
		end else begin
			sync1 <= {addr_strap, sda_in, scl_in};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
			filt_d <= filt;
		end
	end

	assign scl_f = filt[0];
	assign sda_f = filt[1];
	assign strap_f = filt[2];
	assign scl_rise = scl_f && !filt_d[0];
	assign scl_fall = !scl_f && filt_d[0];
	assign start_det = scl_f && filt_d[0] && !sda_f && filt_d[1];
	assign stop_det = scl_f && filt_d[0] && sda_f && !filt_d[1];

	// settle count: the sync chain resets to ones, which a grounded strap
	// would otherwise leave behind as a level seen high
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			settle <= 3'h0;
		else if (settle != SYNC_SETTLE)
			settle <= settle + 3'h1;
	end

	// strap watcher: a strap that never goes high is ground, never low is supply,
	// otherwise it follows whichever bus line it never disagreed with
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			seen_low <= 1'b0;
			seen_high <= 1'b0;
			seen_ne_scl <= 1'b0;
			seen_ne_sda <= 1'b0;
		end else if (settle == SYNC_SETTLE) begin
			seen_low <= seen_low | !strap_f;
			seen_high <= seen_high | strap_f;
			seen_ne_scl <= seen_ne_scl | (strap_f ^ scl_f);
			seen_ne_sda <= seen_ne_sda | (strap_f ^ sda_f);
		end
	end

	// decode of the strap into two address bits
	always_comb begin
		if (!seen_high)
			strap_bits = 2'b00;
		else if (!seen_low)
			strap_bits = 2'b11;
		else if (!seen_ne_scl)
			strap_bits = 2'b01;
		else
			strap_bits = 2'b10;
	end
	assign own_addr = {ADDR_FIXED, strap_bits};

	assign byte_in = scl_fall && cnt == BYTE_DONE;
	assign wr_now = st == ST_WDATA && byte_in;
	assign page_wr = wr_now && ptr == OFS_PAGE_SELECT;
	assign load_rd = scl_fall && ((st == ST_ACK_ADDR && rw) || (st == ST_ACK_R));

	// read mux for the direct registers; write-only ones read as zero
	always_comb begin
		case (ptr)
			OFS_INT_STATUS: rd_local = int_status;
			OFS_IDENT: rd_local = {own_addr, 1'b0};
			OFS_PAGE_LOCK: rd_local = lock;
			default: rd_local = 8'h00;
		endcase
	end

	// bit level protocol engine; sda only changes just after scl falls
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= ST_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			txreg <= 8'hff;
			rw <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (stop_det) begin
			st <= ST_IDLE;
			sda_oe_n <= 1'b1;
		end else if (start_det) begin
			st <= ST_ADDR;
			cnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			shreg <= {shreg[6:0], sda_f};
			cnt <= cnt + 4'h1;
			if (st == ST_ACK_R && sda_f)
				st <= ST_IDLE; // master refused more data
		end else if (scl_fall) begin
			case (st)
				ST_ADDR: begin
					if (cnt == BYTE_DONE && shreg[7:1] == own_addr) begin
						st <= ST_ACK_ADDR;
						rw <= shreg[0];
						sda_oe_n <= 1'b0;
					end else if (cnt == BYTE_DONE) begin
						st <= ST_IDLE; // not ours, stay off the line
					end
				end
				ST_ACK_ADDR: begin
					cnt <= 4'h0;
					if (rw) begin
						st <= ST_RDATA;
						txreg <= {((ptr < OFS_LOCAL_BASE) ? reg_rdata : rd_local)};
						sda_oe_n <= (ptr < OFS_LOCAL_BASE) ? reg_rdata[7] : rd_local[7];
					end else begin
						st <= ST_REG;
						sda_oe_n <= 1'b1;
					end
				end
				ST_REG: begin
					if (cnt == BYTE_DONE) begin
						st <= ST_ACK_REG;
						sda_oe_n <= 1'b0;
					end
				end
				ST_ACK_REG, ST_ACK_W: begin
					st <= ST_WDATA;
					cnt <= 4'h0;
					sda_oe_n <= 1'b1;
				end
				ST_WDATA: begin
					if (cnt == BYTE_DONE) begin
						st <= ST_ACK_W;
						sda_oe_n <= 1'b0;
					end
				end
				ST_RDATA: begin
					txreg <= {txreg[6:0], 1'b1};
					sda_oe_n <= (cnt == BYTE_DONE) ? 1'b1 : txreg[6];
					if (cnt == BYTE_DONE)
						st <= ST_ACK_R;
				end
				ST_ACK_R: begin
					st <= ST_RDATA;
					cnt <= 4'h0;
					txreg <= (ptr < OFS_LOCAL_BASE) ? reg_rdata : rd_local;
					sda_oe_n <= (ptr < OFS_LOCAL_BASE) ? reg_rdata[7] : rd_local[7];
				end
				default: begin
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// register pointer: set by the register offset byte, stepped per written or read byte
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			ptr <= 8'h00;
		else if (st == ST_REG && byte_in)
			ptr <= shreg;
		else if (wr_now || load_rd)
			ptr <= ptr + 8'h01;
	end

	// forwarding of paged writes; direct offsets get no reg_wr strobe but still show on reg_wr_addr and reg_wdata
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_wr <= 1'b0;
			reg_wr_addr <= 8'h00;
			reg_wdata <= 8'h00;
			reg_rd_addr <= 8'h00;
		end else begin
			reg_wr <= wr_now && ptr < OFS_LOCAL_BASE;
			reg_rd_addr <= ptr;
			if (wr_now) begin
				reg_wr_addr <= ptr;
				reg_wdata <= shreg;
			end
		end
	end

	// page select and its one-shot key; a bad value still spends the key
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_page <= RST_PAGE_SELECT;
			lock <= RST_PAGE_LOCK;
		end else if (page_wr && lock == PAGE_UNLOCK_KEY) begin
			lock <= 8'h00;
			if (shreg <= PAGE_MAX)
				reg_page <= shreg;
		end else if (wr_now && ptr == OFS_PAGE_LOCK) begin
			lock <= shreg;
		end
	end

	// interrupt mask, write only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			int_mask <= RST_INT_MASK;
		else if (wr_now && ptr == OFS_INT_MASK)
			int_mask <= shreg & 8'h13;
	end

	// sticky event flags, cleared by reading status; a new event wins the clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			int_status <= 8'h00;
		end else begin
			int_status[BIT_SHORT] <= short_event |
				(int_status[BIT_SHORT] && !(load_rd && ptr == OFS_INT_STATUS));
			int_status[BIT_OPEN] <= open_event |
				(int_status[BIT_OPEN] && !(load_rd && ptr == OFS_INT_STATUS));
		end
	end

	assign irq_cond = (int_status[BIT_SHORT] && int_mask[BIT_SHORT]) ||
		(int_status[BIT_OPEN] && int_mask[BIT_OPEN]);

	// low time counter; expiry only takes effect with auto clear enabled
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt <= 20'h00000;
			expired <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else if (!irq_cond) begin
			low_cnt <= 20'h00000;
			expired <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else begin
			if (!interrupt_out_n && low_cnt != AUTO_CLR_CYCLES[19:0])
				low_cnt <= low_cnt + 20'h00001;
			if (!interrupt_out_n && low_cnt == AUTO_CLR_CYCLES[19:0] &&
					int_mask[BIT_AUTO_CLEAR])
				expired <= 1'b1;
			interrupt_out_n <= expired || (!interrupt_out_n &&
				low_cnt == AUTO_CLR_CYCLES[19:0] && int_mask[BIT_AUTO_CLEAR]);
		end
	end

	// always low, pulls only through the enable
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// checks
	a_addr_ack: assert property (@(posedge mclk) disable iff (sys_rst)
		(st == ST_ADDR && byte_in && !stop_det && !start_det && shreg[7:1] == own_addr)
		|=> (!sda_oe_n && st == ST_ACK_ADDR)) else $error("matching address not acked");
	a_addr_miss: assert property (@(posedge mclk) disable iff (sys_rst)
		(st == ST_ADDR && byte_in && !stop_det && !start_det && shreg[7:1] != own_addr)
		|=> (sda_oe_n && st == ST_IDLE)) else $error("foreign address acked");
	a_gnd_strap: assert property (@(posedge mclk) disable iff (sys_rst)
		(!seen_high && !$past(strap_f)) |-> own_addr == 7'h30) else $error("ground strap wrong");
	a_idle_free: assert property (@(posedge mclk) disable iff (sys_rst)
		stop_det |=> (st == ST_IDLE && sda_oe_n)[*2]) else $error("sda held after stop");
	a_start_addr: assert property (@(posedge mclk) disable iff (sys_rst)
		(start_det && !stop_det) |=> (st == ST_ADDR && cnt == 4'h0)) else $error("start missed");
	a_ptr_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_now && !stop_det && !start_det) |=> (ptr == $past(ptr) + 8'h01 && !sda_oe_n))
		else $error("pointer not stepped");
	a_write_fwd: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_now && !stop_det && !start_det && ptr < OFS_LOCAL_BASE) |=>
		(reg_wr && reg_wr_addr == $past(ptr) && reg_wdata == $past(shreg)))
		else $error("paged write lost");
	a_page_lock: assert property (@(posedge mclk) disable iff (sys_rst)
		(lock != PAGE_UNLOCK_KEY) |=> $stable(reg_page)) else $error("locked page changed");
	a_key_once: assert property (@(posedge mclk) disable iff (sys_rst)
		(page_wr && !stop_det && !start_det && lock == PAGE_UNLOCK_KEY) |=> lock == 8'h00)
		else $error("key not spent");
	a_page_range: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_page <= PAGE_MAX) else $error("page out of range");
	a_auto_rel: assert property (@(posedge mclk) disable iff (sys_rst)
		(irq_cond && !interrupt_out_n && low_cnt == AUTO_CLR_CYCLES[19:0] &&
		int_mask[BIT_AUTO_CLEAR]) ##1 irq_cond |-> interrupt_out_n)
		else $error("interrupt not auto cleared");
	c_read_byte: cover property (@(posedge mclk) disable iff (sys_rst)
		st == ST_ACK_ADDR && rw ##1 st == ST_RDATA);
	c_page_set: cover property (@(posedge mclk) disable iff (sys_rst)
		page_wr && lock == PAGE_UNLOCK_KEY);
	c_auto_clr: cover property (@(posedge mclk) disable iff (sys_rst)
		irq_cond && $rose(interrupt_out_n));
endmodule // ipr_top

`default_nettype wire

// ### test/ipr_master.sv
// i2c bus master model for the paged register front end, 80 ns bit period
// assumes the bench resolves sda from both pull-downs over a pull-up
`timescale 1ns/100ps
`default_nettype none
module ipr_master (
	// clock
	input wire logic mclk,
	// bus lines
	input wire logic sda_wire,
	output logic scl_pin,
	output logic sda_pull_n
);
	// lines start released so the bus idles high
	initial begin
		scl_pin = 1'b1;
		sda_pull_n = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// start and repeated start alike: sda falls while scl is high
	// scl stays low long enough for a slave acknowledge to be released first
	task automatic bus_start();
		sda_pull_n <= 1'b1;
		wait_clk(6);
		scl_pin <= 1'b1;
		wait_clk(4);
		sda_pull_n <= 1'b0;
		wait_clk(4);
		scl_pin <= 1'b0;
	endtask
	// stop: sda rises while scl is high
	task automatic bus_stop();
		wait_clk(2);
		sda_pull_n <= 1'b0;
		wait_clk(2);
		scl_pin <= 1'b1;
		wait_clk(4);
		sda_pull_n <= 1'b1;
		wait_clk(4);
	endtask
	// the slave answers about five clocks after scl falls, so the low phase
	// takes six of the eight clocks and data moves early in it
	task automatic bit_xfer(input logic b, output logic r);
		wait_clk(2);
		sda_pull_n <= b;
		wait_clk(4);
		scl_pin <= 1'b1;
		wait_clk(2);
		r = sda_wire;
		scl_pin <= 1'b0;
	endtask
	// byte out msb first, line released for the acknowledge pulse
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask
	// byte in msb first, then acknowledge or, on the last byte, not
	task automatic byte_in(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, d[i]);
		end
		bit_xfer(last, r);
	endtask
endmodule // ipr_master
`default_nettype wire

// ### test/tb_ipr_top.sv
// self-checking bench for the paged register front end
// assumes a page store answering combinationally; strap wiring switched across resets
`timescale 1ns/100ps
`default_nettype none
module tb_ipr_top;
	import ipr_pkg::*;
	localparam int AC = 50;
	logic mclk, sys_rst, scl, sda_pull_n, short_event, open_event;
	logic sda_out, sda_oe_n, reg_wr, interrupt_out_n;
	logic [7:0] reg_page, reg_wr_addr, reg_wdata, reg_rd_addr, reg_rdata;
	logic [7:0] d0, d1;
	logic [1:0] strap_mode, abits;
	wire logic strap_pin;
	logic [23:0] wr_log [$];
	wire logic sda_wire;
	int error_cnt, compares;
	// page store contents are a fixed pattern of page and offset
	function automatic logic [7:0] page_data(input logic [7:0] p, input logic [7:0] a);
		return {p[3:0], 4'h0} ^ a;
	endfunction
	// open drain bus with pull-up
	assign sda_wire = ~(~sda_pull_n | (~sda_oe_n & ~sda_out));
	assign reg_rdata = page_data(reg_page, reg_rd_addr);
	// strap wiring: ground, supply, the clock line or the data line
	assign strap_pin = (strap_mode == 2'h0) ? 1'b0 : (strap_mode == 2'h1) ? 1'b1 :
		(strap_mode == 2'h2) ? scl : sda_wire;
	ipr_top #(.AUTO_CLR_CYCLES(AC)) ipr_top_i (.mclk(mclk), .sys_rst(sys_rst),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_strap(strap_pin), .short_event(short_event), .open_event(open_event),
		.reg_page(reg_page), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
		.reg_wdata(reg_wdata), .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata),
		.interrupt_out_n(interrupt_out_n));
	ipr_master ipr_master_i (.mclk(mclk), .sda_wire(sda_wire), .scl_pin(scl),
		.sda_pull_n(sda_pull_n));
	// record every paged write with the page it went to
	always @(posedge mclk) begin
		if (reg_wr === 1'b1) wr_log.push_back({reg_page, reg_wr_addr, reg_wdata});
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic finish_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_seq(input logic [7:0] ofs, input logic [7:0] d [$]);
		logic a;
		ipr_master_i.bus_start();
		ipr_master_i.byte_out({ADDR_FIXED, abits, 1'b0}, a);
		chk("addr ack", 8'h01, {7'h00, a});
		ipr_master_i.byte_out(ofs, a);
		chk("reg ack", 8'h01, {7'h00, a});
		foreach (d[i]) begin
			ipr_master_i.byte_out(d[i], a);
			chk("data ack", 8'h01, {7'h00, a});
		end
		ipr_master_i.bus_stop();
	endtask
	// two bytes read after a repeated start, the second not acknowledged
	task automatic rd2(input logic [7:0] ofs);
		logic a;
		ipr_master_i.bus_start();
		ipr_master_i.byte_out({ADDR_FIXED, abits, 1'b0}, a);
		ipr_master_i.byte_out(ofs, a);
		ipr_master_i.bus_start();
		ipr_master_i.byte_out({ADDR_FIXED, abits, 1'b1}, a);
		chk("read addr ack", 8'h01, {7'h00, a});
		ipr_master_i.byte_in(1'b0, d0);
		ipr_master_i.byte_in(1'b1, d1);
		ipr_master_i.bus_stop();
	endtask
	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (interrupt_out_n !== lvl && n < 200) begin
			@(posedge mclk);
			n++;
		end
		chk("irq level", {7'h00, lvl}, {7'h00, interrupt_out_n});
		if (interrupt_out_n !== lvl) finish_test();
	endtask
	task automatic pulse(input logic s);
		if (s) short_event <= 1'b1;
		else open_event <= 1'b1;
		@(posedge mclk);
		short_event <= 1'b0;
		open_event <= 1'b0;
	endtask
	task automatic t_reset();
		chk("page", 8'h00, reg_page);
		chk("irq", 8'h01, {7'h00, interrupt_out_n});
		chk("sda release", 8'h01, {7'h00, sda_oe_n});
		$display("t_reset done");
	endtask
	task automatic t_addr();
		logic a;
		rd2(OFS_IDENT);
		chk("ident", {ADDR_FIXED, 2'b00, 1'b0}, d0);
		ipr_master_i.bus_start();
		ipr_master_i.byte_out({5'h0d, 2'b00, 1'b0}, a);
		chk("foreign addr", 8'h00, {7'h00, a});
		ipr_master_i.bus_stop();
		ipr_master_i.bus_start();
		ipr_master_i.byte_out({ADDR_FIXED, 2'b11, 1'b0}, a);
		chk("strap bits", 8'h00, {7'h00, a});
		ipr_master_i.bus_stop();
		$display("t_addr done");
	endtask
	task automatic t_page();
		wr_seq(OFS_PAGE_SELECT, '{8'h02});
		chk("locked page", 8'h00, reg_page);
		for (int p = 0; p < 5; p++) begin
			wr_seq(OFS_PAGE_LOCK, '{PAGE_UNLOCK_KEY});
			rd2(OFS_PAGE_LOCK);
			chk("lock readback", PAGE_UNLOCK_KEY, d0);
			wr_seq(OFS_PAGE_SELECT, '{8'(p)});
			chk("page", 8'(p), reg_page);
			rd2(OFS_PAGE_LOCK);
			chk("lock cleared", 8'h00, d0);
		end
		wr_seq(OFS_PAGE_SELECT, '{8'h02});
		chk("one shot", 8'h04, reg_page);
		wr_seq(OFS_PAGE_LOCK, '{PAGE_UNLOCK_KEY});
		wr_seq(OFS_PAGE_SELECT, '{8'h07});
		chk("bad page", 8'h04, reg_page);
		rd2(OFS_PAGE_LOCK);
		chk("key used", 8'h00, d0);
		$display("t_page done");
	endtask
	task automatic t_data();
		wr_log.delete();
		wr_seq(8'h3e, '{8'ha1, 8'hb2, 8'hc3});
		chk("write count", 8'h03, 8'(wr_log.size()));
		foreach (wr_log[i]) begin
			chk("wr page", 8'h04, wr_log[i][23:16]);
			chk("wr addr", 8'h3e + 8'(i), wr_log[i][15:8]);
			chk("wr data", 8'ha1 + 8'(i) * 8'h11, wr_log[i][7:0]);
		end
		rd2(8'h20);
		chk("rd byte0", page_data(8'h04, 8'h20), d0);
		chk("rd byte1", page_data(8'h04, 8'h21), d1);
		$display("t_data done");
	endtask
	task automatic t_irq();
		wr_seq(OFS_INT_MASK, '{8'h12});
		pulse(1'b1);
		wait_irq(1'b0);
		repeat (40) @(posedge mclk);
		chk("held low", 8'h00, {7'h00, interrupt_out_n});
		wait_irq(1'b1);
		rd2(OFS_INT_STATUS);
		chk("status short", 8'h02, d0);
		wr_seq(OFS_INT_MASK, '{8'h02});
		pulse(1'b1);
		wait_irq(1'b0);
		repeat (120) @(posedge mclk);
		chk("no auto clear", 8'h00, {7'h00, interrupt_out_n});
		rd2(OFS_INT_STATUS);
		chk("status short", 8'h02, d0);
		wait_irq(1'b1);
		pulse(1'b0);
		repeat (20) @(posedge mclk);
		chk("open masked", 8'h01, {7'h00, interrupt_out_n});
		rd2(OFS_INT_STATUS);
		chk("status open", 8'h01, d0);
		$display("t_irq done");
	endtask
	// mid-run reset with each other strap wiring; ident follows the decode
	task automatic t_strap();
		for (int m = 1; m < 4; m++) begin
			sys_rst <= 1'b1;
			strap_mode <= 2'(m);
			repeat (3) @(posedge mclk);
			sys_rst <= 1'b0;
			@(posedge mclk);
			chk("rst page", 8'h00, reg_page);
			chk("rst sda", 8'h01, {7'h00, sda_oe_n});
			repeat (8) @(posedge mclk);
			abits = (m == 1) ? 2'b11 : (m == 2) ? 2'b01 : 2'b10;
			rd2(OFS_IDENT);
			chk("strap ident", {ADDR_FIXED, abits, 1'b0}, d0);
		end
		$display("t_strap done");
	endtask
	initial begin
		sys_rst = 1'b1;
		strap_mode = 2'h0;
		abits = 2'b00;
		short_event = 1'b0;
		open_event = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_reset();
		t_addr();
		t_page();
		t_data();
		t_irq();
		t_strap();
		finish_test();
	end
endmodule // tb_ipr_top
`default_nettype wire
